//--- core/flag_bank.sv
`timescale 1ns/1ps
`include "motion_cfg.svh"

// bank of sticky flags; a set in the same cycle as a clear wins
module flag_bank #(
   parameter int W = `FLAG_W
) (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // per-bit set and clear
   input wire logic [W-1:0] set,
   input wire logic [W-1:0] clr,
   // flag state
   output logic [W-1:0] q
);

   logic [W-1:0] next_q;

   // set has priority so no event is lost under a clear
   assign next_q = set | (q & ~clr);

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         q <= '0;
      else
         q <= next_q;
   end

endmodule

//--- core/motion_cfg.svh
`ifndef MOTION_CFG_SVH
`define MOTION_CFG_SVH

// command codes, contiguous so one compare finds unknown codes
`define CMD_W 4
`define CMD_MOVE_TO 4'h0
`define CMD_SHIFT 4'h1
`define CMD_ZERO 4'h2
`define CMD_STOP 4'h3
`define CMD_IMM_STOP 4'h4
`define CMD_LEFT 4'h5
`define CMD_RIGHT 4'h6
`define CMD_LEFT_BORDER 4'h7
`define CMD_RIGHT_BORDER 4'h8
`define CMD_HOMING 4'h9
`define CMD_LOFT 4'hA
`define CMD_SOFT_STOP 4'hB
`define CMD_LAST 4'hB

// command checksum: crc-8, msb first over code then value
`define CRC_W 8
`define CRC_POLY 8'h07
`define CRC_INIT 8'h00

// bit positions in the sticky flag bank
`define FLAG_W 9
`define F_MOTION 0
`define F_UNKNOWN 1
`define F_INTEGRITY 2
`define F_VALUE 3
`define F_EXT 4
`define F_ALGO 5
`define F_SLIP 6
`define F_HOMED 7
`define F_HOT 8

// width of the software error clear vector (bits F_MOTION..F_SLIP)
`define CLR_W 7
`define PIN_W 7

`endif

//--- core/motion_pkg.sv
package motion_pkg;

   // command reported as last executed or executing
   typedef enum logic [3:0] {
      lc_move_to, lc_shift, lc_move_left, lc_move_right, lc_stop,
      lc_homing, lc_loft, lc_soft_stop, lc_unknown
   } last_cmd_e;

   // winding power state
   typedef enum logic [2:0] {
      pw_off, pw_short, pw_norm, pw_reduced, pw_max
   } power_e;

   // encoder health
   typedef enum logic [2:0] {
      enc_absent, enc_unknown, enc_fault, enc_reversed, enc_ok
   } encoder_e;

endpackage

//--- core/motion_status.sv
// Functional notes
// - move and shift are computed from the stored target, not measured position.
// - move loads the value into target; shift adds the offset to target.
// - zero clears target only when no movement is in progress.
// - stop, jogs and border moves leave the target unchanged.
// - supply voltage outside its allowed window enters alarm.
// - supply current above its limit enters alarm.
// - board temperature above its limit enters alarm.
// - without latching, alarm drops once all causes have ended.
// - with latching, alarm persists until the host sends immediate stop.
// - immediate stop halts motion, resets alarm unless a cause is still live, empties the sync buffer.
// - report last command from a fixed set, plus motion command error.
// - report winding power state as one of five values.
// - expose seven live input pin flags.
// - homed set on homing success, cleared when calibration is lost.
// - report encoder state as one of five codes.
// - driver overheat raises a flag and inhibits control until cooled.
// - with position control on, large encoder-step difference sets slip.
// - unrecognised command code sets the unknown command error.
// - checksum mismatch sets integrity error and the command is dropped.
// - out of range values are clamped, applied, and flagged.
// - external input error when the pin is asserted and enabled.
// - control algorithm failure sets its error flag.
`timescale 1ns/1ps
`include "motion_cfg.svh"

module motion_status #(
   parameter int POS_W = 32,
   parameter int MON_W = 16
) (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // command port, one command per cycle while cmd_valid is high
   input wire logic cmd_valid,
   input wire logic [`CMD_W-1:0] cmd_code,
   input wire logic signed [POS_W-1:0] cmd_value,
   input wire logic [`CRC_W-1:0] cmd_crc,
   input wire logic signed [POS_W-1:0] value_min,
   input wire logic signed [POS_W-1:0] value_max,
   // motion feedback
   input wire logic moving,
   input wire logic homing_done,
   input wire logic calibration_lost,
   // supply monitor and its limits
   input wire logic [MON_W-1:0] supply_voltage,
   input wire logic [MON_W-1:0] supply_current,
   input wire logic [MON_W-1:0] board_temp,
   input wire logic [MON_W-1:0] volt_min,
   input wire logic [MON_W-1:0] volt_max,
   input wire logic [MON_W-1:0] current_max,
   input wire logic [MON_W-1:0] temp_max,
   input wire logic sticky_alarm_en,
   // driver
   input wire motion_pkg::power_e power_request,
   input wire logic driver_hot,
   input wire logic driver_cooled,
   // live pins: left, right, gpio, brake, revolution, sync in, sync out
   input wire logic [`PIN_W-1:0] pins,
   // encoder and position control
   input wire logic encoder_present,
   input wire logic encoder_known,
   input wire logic encoder_fault,
   input wire logic encoder_reversed,
   input wire logic position_control_en,
   input wire logic signed [POS_W-1:0] encoder_position,
   input wire logic signed [POS_W-1:0] step_position,
   input wire logic [POS_W-1:0] slip_threshold,
   // error sources and software clear
   input wire logic external_io_signal,
   input wire logic external_io_signal_error_en,
   input wire logic algorithm_fail,
   input wire logic [`CLR_W-1:0] error_clear,
   // motion outputs
   output logic signed [POS_W-1:0] target_position,
   output logic halt,
   output logic sync_buffer_clear,
   output logic motor_enable,
   output logic alarm,
   // status outputs
   output motion_pkg::last_cmd_e last_command,
   output motion_pkg::power_e winding_state,
   output motion_pkg::encoder_e encoder_state,
   output logic [`PIN_W-1:0] input_flags,
   output logic motion_command_error,
   output logic homed_flag,
   output logic driver_overheat_flag,
   output logic slip_flag,
   output logic unknown_command_error,
   output logic integrity_error,
   output logic value_range_error,
   output logic external_input_error,
   output logic control_algorithm_error
);
   import motion_pkg::*;

   localparam int CRC_IN = `CMD_W + POS_W;

   // crc-8 over code and value, msb first
   function automatic logic [`CRC_W-1:0] crc8(input logic [CRC_IN-1:0] d);
      logic [`CRC_W-1:0] c;
      logic fb;
      c = `CRC_INIT;
      for (int i = CRC_IN - 1; i >= 0; i--)
      begin
         fb = c[`CRC_W-1] ^ d[i];
         c = {c[`CRC_W-2:0], 1'b0};
         if (fb)
            c = c ^ `CRC_POLY;
      end
      return c;
   endfunction

   // command map onto the reported set
   function automatic last_cmd_e map_cmd(input logic [`CMD_W-1:0] c);
      case (c)
         `CMD_MOVE_TO: map_cmd = lc_move_to;
         `CMD_SHIFT: map_cmd = lc_shift;
         `CMD_STOP, `CMD_IMM_STOP: map_cmd = lc_stop;
         `CMD_LEFT, `CMD_LEFT_BORDER: map_cmd = lc_move_left;
         `CMD_RIGHT, `CMD_RIGHT_BORDER: map_cmd = lc_move_right;
         `CMD_HOMING: map_cmd = lc_homing;
         `CMD_LOFT: map_cmd = lc_loft;
         `CMD_SOFT_STOP: map_cmd = lc_soft_stop;
         default: map_cmd = lc_unknown;
      endcase
   endfunction

   // command decode; a bad checksum drops the whole command
   logic crc_ok;
   logic cmd_take;
   logic known_cmd;
   logic cmd_exec;
   logic is_move;
   logic is_shift;
   logic is_zero;
   logic is_istop;
   logic is_motion;
   assign crc_ok = crc8({cmd_code, cmd_value}) == cmd_crc;
   assign cmd_take = cmd_valid & crc_ok;
   assign known_cmd = cmd_code <= `CMD_LAST;
   assign cmd_exec = cmd_take & known_cmd;
   assign is_move = cmd_exec & (cmd_code == `CMD_MOVE_TO);
   assign is_shift = cmd_exec & (cmd_code == `CMD_SHIFT);
   assign is_zero = cmd_exec & (cmd_code == `CMD_ZERO);
   assign is_istop = cmd_exec & (cmd_code == `CMD_IMM_STOP);
   assign is_motion = cmd_exec & ~is_zero & ~is_istop
      & (cmd_code != `CMD_STOP) & (cmd_code != `CMD_SOFT_STOP);

   // clamp parameter into its valid window; the corrected value is used
   logic signed [POS_W-1:0] clamped;
   logic value_bad;
   assign clamped = (cmd_value < value_min) ? value_min
      : (cmd_value > value_max) ? value_max : cmd_value;
   assign value_bad = (is_move | is_shift) & (clamped != cmd_value);

   // target arithmetic wraps in two's complement like the counter it tracks
   logic signed [POS_W-1:0] shift_sum;
   logic signed [POS_W-1:0] next_target;
   assign shift_sum = target_position + clamped;
   assign next_target = is_move ? clamped
      : is_shift ? shift_sum
      : (is_zero & ~moving) ? '0
      : target_position;

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         target_position <= '0;
      else
         target_position <= next_target;
   end

   // alarm causes from the supply and board monitors
   logic volt_bad;
   logic curr_bad;
   logic temp_bad;
   logic alarm_cause;
   logic next_alarm;
   assign volt_bad = (supply_voltage < volt_min) | (supply_voltage > volt_max);
   assign curr_bad = supply_current > current_max;
   assign temp_bad = board_temp > temp_max;
   assign alarm_cause = volt_bad | curr_bad | temp_bad;
   // a live cause beats the stop, otherwise the alarm would flicker off
   assign next_alarm = alarm_cause
      | (alarm & sticky_alarm_en & ~is_istop);

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         alarm <= 1'b0;
      else
         alarm <= next_alarm;
   end

   // immediate stop strobes, registered one-cycle pulses
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         halt <= 1'b0;
         sync_buffer_clear <= 1'b0;
      end
      else
      begin
         halt <= is_istop;
         sync_buffer_clear <= is_istop;
      end
   end

   // control is inhibited while in alarm or until the driver cools
   assign motor_enable = ~alarm & ~driver_overheat_flag;

   // slip: magnitude of encoder minus step position, one bit wider
   logic signed [POS_W:0] pos_diff;
   logic [POS_W:0] pos_mag;
   logic slip_hit;
   assign pos_diff = {encoder_position[POS_W-1], encoder_position}
      - {step_position[POS_W-1], step_position};
   assign pos_mag = pos_diff[POS_W] ? -pos_diff : pos_diff;
   assign slip_hit = position_control_en & (pos_mag > {1'b0, slip_threshold});

   // sticky flags; software clears the error bits, hardware clears homed
   // and overheat
   logic [`FLAG_W-1:0] flag_set;
   logic [`FLAG_W-1:0] flag_clr;
   logic [`FLAG_W-1:0] flags;
   assign flag_set[`F_MOTION] = is_motion & ~motor_enable;
   assign flag_set[`F_UNKNOWN] = cmd_take & ~known_cmd;
   assign flag_set[`F_INTEGRITY] = cmd_valid & ~crc_ok;
   assign flag_set[`F_VALUE] = value_bad;
   assign flag_set[`F_EXT] = external_io_signal & external_io_signal_error_en;
   assign flag_set[`F_ALGO] = algorithm_fail;
   assign flag_set[`F_SLIP] = slip_hit;
   assign flag_set[`F_HOMED] = homing_done;
   assign flag_set[`F_HOT] = driver_hot;
   assign flag_clr[`CLR_W-1:0] = error_clear;
   assign flag_clr[`F_HOMED] = calibration_lost | is_istop;
   assign flag_clr[`F_HOT] = driver_cooled;

   flag_bank #(
      .W(`FLAG_W)
   ) u_flags (
      .clock(clock),
      .rstn(rstn),
      .set(flag_set),
      .clr(flag_clr),
      .q(flags)
   );

   assign motion_command_error = flags[`F_MOTION];
   assign unknown_command_error = flags[`F_UNKNOWN];
   assign integrity_error = flags[`F_INTEGRITY];
   assign value_range_error = flags[`F_VALUE];
   assign external_input_error = flags[`F_EXT];
   assign control_algorithm_error = flags[`F_ALGO];
   assign slip_flag = flags[`F_SLIP];
   assign homed_flag = flags[`F_HOMED];
   assign driver_overheat_flag = flags[`F_HOT];

   // reported states; zero leaves the last command as it was
   encoder_e next_encoder;
   last_cmd_e next_last;
   power_e next_power;
   assign next_encoder = ~encoder_present ? enc_absent
      : ~encoder_known ? enc_unknown
      : encoder_fault ? enc_fault
      : encoder_reversed ? enc_reversed : enc_ok;
   assign next_last = (cmd_take & ~is_zero) ? map_cmd(cmd_code) : last_command;
   assign next_power = motor_enable ? power_request : pw_off;

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         last_command <= lc_unknown;
         winding_state <= pw_off;
         encoder_state <= enc_absent;
         input_flags <= '0;
      end
      else
      begin
         last_command <= next_last;
         winding_state <= next_power;
         encoder_state <= next_encoder;
         input_flags <= pins;
      end
   end

   // checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   sequence s_istop_pulse;
      halt && sync_buffer_clear ##1 !halt && !sync_buffer_clear;
   endsequence

   property p_move;
      is_move |=> target_position == $past(clamped);
   endproperty
   a_move: assert property (p_move) else $error("move target wrong");

   property p_shift;
      is_shift |=> target_position == $past(target_position) + $past(clamped);
   endproperty
   a_shift: assert property (p_shift) else $error("shift target wrong");

   property p_zero;
      is_zero |=> target_position == ($past(moving) ? $past(target_position) : '0);
   endproperty
   a_zero: assert property (p_zero) else $error("zero target wrong");

   property p_keep;
      cmd_exec && (cmd_code inside {`CMD_STOP, `CMD_LEFT, `CMD_RIGHT,
         `CMD_LEFT_BORDER, `CMD_RIGHT_BORDER}) |=> $stable(target_position);
   endproperty
   a_keep: assert property (p_keep) else $error("jog changed target");

   property p_cause;
      volt_bad || curr_bad || temp_bad |=> alarm;
   endproperty
   a_cause: assert property (p_cause) else $error("alarm not raised");

   property p_auto_clear;
      alarm && !alarm_cause && !sticky_alarm_en |=> !alarm;
   endproperty
   a_auto_clear: assert property (p_auto_clear) else $error("alarm stuck");

   property p_latch;
      alarm && sticky_alarm_en && !is_istop |=> alarm;
   endproperty
   a_latch: assert property (p_latch) else $error("latched alarm lost");

   // the pulse only drops when no second stop follows right behind
   property p_istop;
      is_istop && !alarm_cause ##1 !is_istop |-> s_istop_pulse and !alarm;
   endproperty
   a_istop: assert property (p_istop) else $error("stop sequence wrong");

   property p_crc;
      cmd_valid && !crc_ok |=> integrity_error && $stable(target_position);
   endproperty
   a_crc: assert property (p_crc) else $error("bad crc accepted");

   property p_unknown;
      cmd_take && !known_cmd |=> unknown_command_error && last_command == lc_unknown;
   endproperty
   a_unknown: assert property (p_unknown) else $error("unknown not flagged");

   property p_hot;
      driver_hot |=> driver_overheat_flag && !motor_enable ##1 winding_state == pw_off;
   endproperty
   a_hot: assert property (p_hot) else $error("overheat not inhibiting");

   property p_homed;
      homing_done |=> homed_flag;
   endproperty
   a_homed: assert property (p_homed) else $error("homed not set");

endmodule

//--- verification/motion_host.sv
`timescale 1ns/1ps
// host side: one checksummed command per rising edge, port idles between bursts
module motion_host (
   // clock
   input wire logic clock,
   // command port
   output logic cmd_valid,
   output logic [3:0] cmd_code,
   output logic signed [31:0] cmd_value,
   output logic [7:0] cmd_crc
);
   // crc-8 poly 07, msb first over code then value
   function automatic logic [7:0] crc8(input logic [35:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 35; i >= 0; i--)
         c = {c[6:0], 1'h0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
      return c;
   endfunction

   // idle port at time zero
   initial
   begin
      cmd_valid = 1'h0;
      cmd_code = 4'h0;
      cmd_value = 32'h0;
      cmd_crc = 8'h00;
   end

   // called at a falling edge; holds the word over one rising edge, valid stays up
   task automatic send(input logic [3:0] code, input logic [31:0] val, input logic bad);
      cmd_valid = 1'h1;
      cmd_code = code;
      cmd_value = val;
      cmd_crc = crc8({code, val}) ^ {7'h00, bad};
      @(negedge clock);
   endtask

   // released lines show the inverse so stale data can never pass for fresh
   task automatic idle;
      cmd_valid = 1'h0;
      cmd_code = ~cmd_code;
      cmd_value = ~cmd_value;
      cmd_crc = ~cmd_crc;
      @(negedge clock);
   endtask
endmodule

//--- verification/motion_target_and_alarm_status_test.sv
`timescale 1ns/1ps
module motion_target_and_alarm_status_test;
   import motion_pkg::*;
   // stimulus, changed only on the falling edge
   logic clock = 1'h0, rstn = 1'h0, moving = 1'h0, homing_done = 1'h0, calibration_lost = 1'h0;
   logic sticky_alarm_en = 1'h0, driver_hot = 1'h0, driver_cooled = 1'h0;
   logic encoder_present = 1'h0, encoder_known = 1'h0, encoder_fault = 1'h0;
   logic encoder_reversed = 1'h0, position_control_en = 1'h0;
   logic external_io_signal = 1'h0, external_io_signal_error_en = 1'h1, algorithm_fail = 1'h0;
   logic [6:0] pins = 7'h00, error_clear = 7'h00;
   logic [15:0] supply_voltage = 16'h0100, supply_current = 16'h0010, board_temp = 16'h0020;
   logic [15:0] volt_min = 16'h0080, volt_max = 16'h0200, current_max = 16'h0040;
   logic [15:0] temp_max = 16'h0050;
   logic signed [31:0] value_min = 32'hFFFFFC18, value_max = 32'h000003E8;
   logic signed [31:0] encoder_position = 32'h0, step_position = 32'h0;
   logic [31:0] slip_threshold = 32'h0000000A;
   power_e power_request = pw_norm;
   // host port and observed outputs
   logic cmd_valid;
   logic [3:0] cmd_code;
   logic signed [31:0] cmd_value, target_position;
   logic [7:0] cmd_crc;
   logic halt, sync_buffer_clear, motor_enable, alarm, motion_command_error, homed_flag;
   logic driver_overheat_flag, slip_flag, unknown_command_error, integrity_error;
   logic value_range_error, external_input_error, control_algorithm_error;
   logic [6:0] input_flags;
   last_cmd_e last_command;
   power_e winding_state;
   encoder_e encoder_state;
   int n_fail = 0, cmp_count = 0;

   always #10 clock = ~clock;

   motion_host i_host (.clock, .cmd_valid, .cmd_code, .cmd_value, .cmd_crc);

   motion_status i_dut (.clock, .rstn, .cmd_valid, .cmd_code, .cmd_value, .cmd_crc,
      .value_min, .value_max, .moving, .homing_done, .calibration_lost, .supply_voltage,
      .supply_current, .board_temp, .volt_min, .volt_max, .current_max, .temp_max,
      .sticky_alarm_en, .power_request, .driver_hot, .driver_cooled, .pins,
      .encoder_present, .encoder_known, .encoder_fault, .encoder_reversed,
      .position_control_en, .encoder_position, .step_position, .slip_threshold,
      .external_io_signal, .external_io_signal_error_en, .algorithm_fail, .error_clear,
      .target_position, .halt, .sync_buffer_clear, .motor_enable, .alarm, .last_command,
      .winding_state, .encoder_state, .input_flags, .motion_command_error, .homed_flag,
      .driver_overheat_flag, .slip_flag, .unknown_command_error, .integrity_error,
      .value_range_error, .external_input_error, .control_algorithm_error);

   // compare tasks: single flags and words
   task automatic chk1(input logic got, input logic exp, input string what);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED %0t %s", $time, what);
      end
   endtask
   task automatic chkv(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED %0t %s", $time, what);
      end
   endtask
   // status lags its inputs by one edge
   task automatic tick;
      @(negedge clock);
   endtask

   task automatic t_status;
      logic [3:0] enc [5] = '{4'h0, 4'h8, 4'hE, 4'hD, 4'hC};
      pins = 7'h55;
      tick;
      chkv(input_flags, 7'h55, "pins");
      pins = 7'h2A;
      tick;
      chkv(input_flags, 7'h2A, "pins");
      for (int p = 0; p < 5; p++)
      begin
         power_request = power_e'(p);
         tick;
         chkv(winding_state, p, "winding");
      end
      for (int i = 0; i < 5; i++)
      begin
         {encoder_present, encoder_known, encoder_fault, encoder_reversed} = enc[i];
         tick;
         chkv(encoder_state, i, "encoder");
      end
      homing_done = 1'h1;
      tick;
      homing_done = 1'h0;
      chk1(homed_flag, 1'h1, "homed");
      calibration_lost = 1'h1;
      tick;
      calibration_lost = 1'h0;
      chk1(homed_flag, 1'h0, "homed lost");
      encoder_position = 32'h32;
      tick;
      chk1(slip_flag, 1'h0, "slip off");
      position_control_en = 1'h1;
      tick;
      chk1(slip_flag, 1'h1, "slip");
      step_position = 32'h32;
      external_io_signal = 1'h1;
      external_io_signal_error_en = 1'h0;
      tick;
      chk1(external_input_error, 1'h0, "ext masked");
      external_io_signal_error_en = 1'h1;
      algorithm_fail = 1'h1;
      tick;
      external_io_signal = 1'h0;
      algorithm_fail = 1'h0;
      chk1(external_input_error, 1'h1, "ext");
      chk1(control_algorithm_error, 1'h1, "algo");
      driver_hot = 1'h1;
      tick;
      driver_hot = 1'h0;
      chk1(driver_overheat_flag, 1'h1, "hot");
      chk1(motor_enable, 1'h0, "hot inhibit");
      i_host.send(4'h0, 32'h0, 1'h0);
      chk1(motion_command_error, 1'h1, "motion err");
      i_host.idle;
      driver_cooled = 1'h1;
      tick;
      driver_cooled = 1'h0;
      chk1(motor_enable, 1'h1, "cooled");
   endtask

   // back-to-back commands, every one checked one edge later
   task automatic t_target;
      i_host.send(4'h0, 32'h64, 1'h0);
      chkv(target_position, 32'h64, "move");
      chkv(last_command, lc_move_to, "last move");
      i_host.send(4'h1, 32'hFFFFFFE2, 1'h0);
      chkv(target_position, 32'h46, "shift");
      moving = 1'h1;
      i_host.send(4'h2, 32'h0, 1'h0);
      chkv(target_position, 32'h46, "zero moving");
      moving = 1'h0;
      i_host.send(4'h2, 32'h0, 1'h0);
      chkv(target_position, 32'h0, "zero");
      i_host.send(4'h0, 32'h1388, 1'h0);
      chkv(target_position, 32'h3E8, "clamp");
      chk1(value_range_error, 1'h1, "clamp flag");
   endtask

   task automatic t_codes;
      logic [3:0] code [8] = '{4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB};
      last_cmd_e exp [8] = '{lc_stop, lc_move_left, lc_move_right, lc_move_left,
         lc_move_right, lc_homing, lc_loft, lc_soft_stop};
      for (int i = 0; i < 8; i++)
      begin
         i_host.send(code[i], 32'h4D, 1'h0);
         chkv(last_command, exp[i], "last cmd");
         if (i < 5)
            chkv(target_position, 32'h3E8, "target kept");
      end
      i_host.send(4'hC, 32'h0, 1'h0);
      chk1(unknown_command_error, 1'h1, "unknown");
      chkv(last_command, lc_unknown, "last unknown");
      i_host.send(4'h0, 32'h5, 1'h1);
      chk1(integrity_error, 1'h1, "crc");
      chkv(target_position, 32'h3E8, "crc drop");
      i_host.idle;
      error_clear = 7'h04;
      tick;
      error_clear = 7'h00;
      chk1(integrity_error, 1'h0, "clear");
   endtask

   task automatic t_alarm;
      supply_current = 16'h0050;
      tick;
      chk1(alarm, 1'h1, "current");
      supply_current = 16'h0010;
      tick;
      chk1(alarm, 1'h0, "drop");
      volt_min = 16'h0120;
      tick;
      chk1(alarm, 1'h1, "low volt");
      volt_min = 16'h0080;
      supply_voltage = 16'h0300;
      tick;
      chk1(alarm, 1'h1, "high volt");
      supply_voltage = 16'h0100;
      temp_max = 16'h0010;
      tick;
      chk1(alarm, 1'h1, "temp");
      temp_max = 16'h0050;
      tick;
      chk1(alarm, 1'h0, "drop");
      sticky_alarm_en = 1'h1;
      current_max = 16'h0008;
      tick;
      current_max = 16'h0040;
      tick;
      tick;
      chk1(alarm, 1'h1, "latched");
      i_host.send(4'h4, 32'h0, 1'h0);
      chk1(alarm, 1'h0, "stop clears");
      chk1(halt, 1'h1, "halt");
      chk1(sync_buffer_clear, 1'h1, "sync clear");
      i_host.idle;
      chk1(halt, 1'h0, "halt pulse");
      // a stop with a cause still live must not drop the alarm
      current_max = 16'h0008;
      i_host.send(4'h4, 32'h0, 1'h0);
      chk1(alarm, 1'h1, "stop with live cause");
      i_host.idle;
      current_max = 16'h0040;
      sticky_alarm_en = 1'h0;
      tick;
      chk1(alarm, 1'h0, "released");
   endtask

   // mid-run reset: state goes back, and the first edge after release samples inputs
   task automatic t_reset;
      rstn = 1'h0;
      tick;
      chkv(target_position, 32'h0, "reset target");
      chkv(last_command, lc_unknown, "reset last");
      chk1(alarm, 1'h0, "reset alarm");
      chk1(slip_flag, 1'h0, "reset slip");
      rstn = 1'h1;
      tick;
      chkv(input_flags, 7'h2A, "first edge pins");
      chkv(winding_state, pw_max, "first edge winding");
      chk1(motor_enable, 1'h1, "enabled after reset");
   endtask

   // one exit for both the normal end and the watchdog
   task automatic stop_test;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // reset for two cycles, then the scenarios
   initial
   begin
      repeat (2) @(negedge clock);
      rstn = 1'h1;
      t_status;
      t_target;
      t_codes;
      t_alarm;
      t_reset;
      stop_test;
   end

   // the run needs well under 200 cycles; this allows far more
   initial
   begin
      #100000;
      n_fail++;
      stop_test;
   end
endmodule
